// file: rtl/touch_regs_cfg.svh
// offsets, field positions, reset values and timing counts of the sensor register set
`ifndef TOUCH_REGS_CFG_SVH
`define TOUCH_REGS_CFG_SVH

`define ADDR_PROX_MIN     8'h00
`define ADDR_TO_LOW       8'h01
`define ADDR_TO_HIGH      8'h02
`define ADDR_SLAVE        8'h03
`define ADDR_STATE        8'h04

`define RST_PROX_MIN      8'h00
`define RST_TO_LOW        8'hff
`define RST_TO_HIGH       8'h01
`define RST_SLAVE_ADDR    7'h73

`define ST_RSVD_BIT       7
`define ST_FAULT_MSB      6
`define ST_FAULT_LSB      4

`define SLEEP_MAX_CODE    5'h12
`define CLK_PERIOD_PS     4000
`define MS_PS             1000000000
`define MS_CYCLES         (`MS_PS / `CLK_PERIOD_PS)

`endif

// file: rtl/touch_regs_pkg.sv
// types shared by the sensor register set and its sleep pacer
`default_nettype none
package touch_regs_pkg;

    typedef enum logic [0:0] {
        MODE_ACTIVE = 1'b0,
        MODE_IDLE   = 1'b1
    } mode_t;

    typedef enum logic [1:0] {
        PACE_WAIT  = 2'b00,
        PACE_REQ   = 2'b01,
        PACE_SLEEP = 2'b11
    } pace_state_t;

    typedef struct packed {
        pace_state_t state;
        logic [17:0] ms_div;
        logic [18:0] ms_cnt;
        logic        req;
    } pace_regs_t;

    typedef struct packed {
        logic [7:0]  prox_min;
        logic [7:0]  to_low;
        logic [7:0]  to_high;
        logic [6:0]  addr;
        logic [6:0]  addr_active;
        logic [3:0]  raw;
        logic [3:0]  hold;
        logic [3:0]  flags;
        logic [2:0]  fault;
        logic [15:0] to_cnt;
        mode_t       mode;
        logic [7:0]  rdata;
    } touch_regs_t;

endpackage
`default_nettype wire

// file: rtl/sleep_pacer.sv
// paces sensor scans: back to back when active, a timed sleep between scans when idle
`timescale 1ns/1ps
`default_nettype none
`include "touch_regs_cfg.svh"

module sleep_pacer
    import touch_regs_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // control
    input  wire logic       idle,
    input  wire logic       scan_done,
    input  wire logic [4:0] sleep_code,
    // scan request
    output logic            scan_req
);

    pace_regs_t  r_reg;
    pace_regs_t  r_next;
    logic [18:0] target;
    logic        ms_tick;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        // reserved codes fall back to the shortest sleep
        if (sleep_code > `SLEEP_MAX_CODE)
            target = 19'h00001;
        else
            target = 19'h00001 << sleep_code;
        ms_tick = (r_reg.ms_div == 18'(MS_CYCLES - 1));
        r_next = r_reg;
        unique case (r_reg.state)
            PACE_WAIT:
            begin
                if (scan_done && idle)
                begin
                    r_next.state  = PACE_SLEEP;
                    r_next.ms_div = 18'h00000;
                    r_next.ms_cnt = 19'h00000;
                end
                else if (scan_done)
                    r_next.state = PACE_REQ;
            end
            PACE_SLEEP:
            begin
                r_next.ms_div = ms_tick ? 18'h00000 : r_reg.ms_div + 18'h00001;
                if (ms_tick)
                    r_next.ms_cnt = r_reg.ms_cnt + 19'h00001;
                // leaving idle cuts the sleep short so detection resumes at once
                if (!idle || (ms_tick && r_next.ms_cnt >= target))
                    r_next.state = PACE_REQ;
            end
            PACE_REQ:
                r_next.state = PACE_WAIT;
            default:
                r_next.state = PACE_REQ;
        endcase
        r_next.req = (r_next.state == PACE_REQ);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            r_reg <= '{state: PACE_REQ, ms_div: 18'h00000, ms_cnt: 19'h00000, req: 1'b1};
        else
            r_reg <= r_next;
    end

    assign scan_req = r_reg.req;

    ////////////////////////////////////////////////////////////////////////////////

    a_sleep_abort: assert property (@(posedge clk) disable iff (!resetn)
        (r_reg.state == PACE_SLEEP && !idle) |=> scan_req)
        else $error("sleep not cut short on leaving idle");

endmodule
`default_nettype wire

// file: rtl/touch_regs.sv
// configuration and state registers of the dual-channel proximity and touch controller
`timescale 1ns/1ps
`default_nettype none
`include "touch_regs_cfg.svh"

// What this block does
// - eight-bit minimum proximity threshold, reset zero
// - detection threshold never below programmed minimum
// - adaptive threshold floored by programmed minimum
// - time-out forces detected sensor back released
// - time-out without environment change enters idle
// - idle sleeps between scans, no continuous scanning
// - sleep code n gives 2^n ms, reserved 1ms
// - sixteen-bit reload in two bytes, reset 01ff
// - seven-bit slave address in bits 7:1
// - new address used from next transaction
// - state register read-only, bit 7 zero
// - bits 6:4 report pin fault code
// - bits 3/2 show sensor 1/0 proximity
// - bits 1/0 show sensor 1/0 press
module touch_regs
    import touch_regs_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // byte register access from the serial engine
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       txn_start,
    output logic      [6:0] slave_bus_address,
    // acquisition results
    input  wire logic [7:0] near_shift0,
    input  wire logic [7:0] near_shift1,
    input  wire logic [7:0] near_adapt0,
    input  wire logic [7:0] near_adapt1,
    input  wire logic       touch_raw0,
    input  wire logic       touch_raw1,
    input  wire logic [2:0] fault_code,
    input  wire logic       scan_done,
    input  wire logic [4:0] sleep_code,
    // sensor state
    output logic            sensor1_near_flag,
    output logic            sensor0_near_flag,
    output logic            sensor1_touch_flag,
    output logic            sensor0_touch_flag,
    output logic      [2:0] pin_fault_code,
    output logic            idle_state,
    output logic            scan_request
);

    touch_regs_t       r_reg;
    touch_regs_t       r_next;
    logic [1:0][7:0]   shift;
    logic [1:0][7:0]   adapt;
    logic [1:0][7:0]   eff_thr;
    logic [1:0]        near_raw;
    logic [3:0]        raw_now;
    logic              env_change;
    logic              expire;

    ////////////////////////////////////////////////////////////////////////////////

    assign shift = {near_shift1, near_shift0};
    assign adapt = {near_adapt1, near_adapt0};

    // a zero minimum with zero adaptive threshold detects any shift, even none
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_sensor
            assign eff_thr[gi]  = (adapt[gi] > r_reg.prox_min) ? adapt[gi] : r_reg.prox_min;
            assign near_raw[gi] = (shift[gi] >= eff_thr[gi]);
        end
    endgenerate

    assign raw_now    = {near_raw, touch_raw1, touch_raw0};
    assign env_change = (raw_now != r_reg.raw);
    // a zero reload never expires: the counter stays at zero
    assign expire     = !env_change && scan_done && (r_reg.to_cnt == 16'h0001);

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        r_next = r_reg;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `ADDR_PROX_MIN: r_next.rdata = r_reg.prox_min;
                `ADDR_TO_LOW:   r_next.rdata = r_reg.to_low;
                `ADDR_TO_HIGH:  r_next.rdata = r_reg.to_high;
                `ADDR_SLAVE:    r_next.rdata = {r_reg.addr, 1'b0};
                `ADDR_STATE:    r_next.rdata = {1'b0, r_reg.fault, r_reg.flags};
                default:        r_next.rdata = 8'h00;
            endcase
        end
        if (reg_wr)
        begin
            unique case (reg_addr)
                `ADDR_PROX_MIN: r_next.prox_min = reg_wdata;
                `ADDR_TO_LOW:   r_next.to_low   = reg_wdata;
                `ADDR_TO_HIGH:  r_next.to_high  = reg_wdata;
                `ADDR_SLAVE:    r_next.addr     = reg_wdata[7:1];
                default:        r_next.addr     = r_reg.addr;
            endcase
        end
        // the matcher keeps the old address until the next transaction starts
        if (txn_start)
            r_next.addr_active = r_reg.addr;
        r_next.raw  = raw_now;
        r_next.hold = r_reg.hold & raw_now;
        // a raw change outranks a scan, so a changing sensor never times out
        if (env_change)
        begin
            r_next.to_cnt = {r_reg.to_high, r_reg.to_low};
            r_next.mode   = MODE_ACTIVE;
        end
        else if (scan_done && r_reg.to_cnt != 16'h0000)
        begin
            r_next.to_cnt = r_reg.to_cnt - 16'h0001;
            if (expire)
            begin
                r_next.hold = r_reg.hold | raw_now;
                r_next.mode = MODE_IDLE;
            end
        end
        r_next.flags = raw_now & ~r_next.hold;
        r_next.fault = fault_code;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r_reg             <= '0;
            r_reg.prox_min    <= `RST_PROX_MIN;
            r_reg.to_low      <= `RST_TO_LOW;
            r_reg.to_high     <= `RST_TO_HIGH;
            r_reg.to_cnt      <= {`RST_TO_HIGH, `RST_TO_LOW};
            r_reg.addr        <= `RST_SLAVE_ADDR;
            r_reg.addr_active <= `RST_SLAVE_ADDR;
            r_reg.mode        <= MODE_ACTIVE;
        end
        else
            r_reg <= r_next;
    end

    ////////////////////////////////////////////////////////////////////////////////

    sleep_pacer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_pacer (
        .clk        (clk),
        .resetn     (resetn),
        .idle       (r_reg.mode == MODE_IDLE),
        .scan_done  (scan_done),
        .sleep_code (sleep_code),
        .scan_req   (scan_request)
    );

    assign reg_rdata          = r_reg.rdata;
    assign slave_bus_address  = r_reg.addr_active;
    assign sensor1_near_flag  = r_reg.flags[3];
    assign sensor0_near_flag  = r_reg.flags[2];
    assign sensor1_touch_flag = r_reg.flags[1];
    assign sensor0_touch_flag = r_reg.flags[0];
    assign pin_fault_code     = r_reg.fault;
    assign idle_state         = (r_reg.mode == MODE_IDLE);

    ////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_near_floor: assert property (sensor0_near_flag |-> $past(near_shift0) >= $past(r_reg.prox_min))
        else $error("near flag below programmed minimum");
    a_near_adapt: assert property (sensor1_near_flag |-> $past(near_shift1) >= $past(near_adapt1))
        else $error("near flag below adaptive threshold");
    a_touch_map: assert property (sensor0_touch_flag |-> $past(touch_raw0))
        else $error("touch flag without press");
    a_fault_map: assert property ($past(resetn) |-> pin_fault_code == $past(fault_code))
        else $error("fault code not passed through");
    a_state_ro: assert property (reg_rd && reg_addr == `ADDR_STATE |=> reg_rdata[7] == 1'b0)
        else $error("state bit 7 reads one");
    a_addr_bit0: assert property (reg_rd && reg_addr == `ADDR_SLAVE |=> reg_rdata[0] == 1'b0)
        else $error("address bit 0 reads one");
    a_addr_switch: assert property (txn_start |=> slave_bus_address == $past(r_reg.addr))
        else $error("address not taken at transaction start");
    a_reload_change: assert property (env_change |=> r_reg.to_cnt == $past({r_reg.to_high, r_reg.to_low}))
        else $error("time-out not reloaded on change");
    a_expire_release: assert property (expire |=> idle_state && r_reg.flags == 4'h0)
        else $error("expiry did not release and idle");
    a_write_low: assert property (reg_wr && reg_addr == `ADDR_TO_LOW |=> r_reg.to_low == $past(reg_wdata))
        else $error("reload low byte not written");
    a_write_high: assert property (reg_wr && reg_addr == `ADDR_TO_HIGH
        |=> r_reg.to_high == $past(reg_wdata))
        else $error("reload high byte not written");
    a_prox_write: assert property (reg_wr && reg_addr == `ADDR_PROX_MIN
        |=> r_reg.prox_min == $past(reg_wdata))
        else $error("proximity minimum not written");
    a_count_down: assert property (scan_done && !env_change && r_reg.to_cnt != 16'h0000
        |=> r_reg.to_cnt == $past(r_reg.to_cnt) - 16'h0001)
        else $error("time-out counter did not step down");
    a_idle_exit: assert property (env_change |=> !idle_state)
        else $error("sensor change did not leave idle");
    a_state_flags: assert property (reg_rd && reg_addr == `ADDR_STATE
        |=> reg_rdata[3:0] == $past(r_reg.flags))
        else $error("state byte does not show the flags");
    a_addr_hold: assert property (!txn_start |=> $stable(slave_bus_address))
        else $error("matcher address moved without a transaction start");

    c_expire: cover property (expire);
    c_addr_move: cover property (reg_wr && reg_addr == `ADDR_SLAVE ##[1:20] txn_start);
    c_idle_scan: cover property (idle_state && scan_request);
    c_near_both: cover property (sensor0_near_flag && sensor1_near_flag);
    c_idle_exit: cover property (idle_state ##1 !idle_state);

endmodule
`default_nettype wire

// file: dv/scan_model.sv
// acquisition side model: answers each scan request with one scan done pulse
`timescale 1ns/1ps
`default_nettype none
module scan_model
#(
    parameter int DELAY = 2
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // scan handshake
    input  wire logic scan_request,
    output var  logic scan_done
);
    int cnt;
    // the request raised during reset is a real one, so a scan is pending at release
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt       <= DELAY;
            scan_done <= 1'b0;
        end
        else
        begin
            scan_done <= (cnt == 1);
            if (scan_request)
                cnt <= DELAY;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// file: dv/tb_touch_regs.sv
// self-checking bench of the sensor register set
`timescale 1ns/1ps
`default_nettype none
module tb_touch_regs;
    localparam int MSC = 4;
    logic       clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, txn_start = 1'b0;
    logic       touch_raw0 = 1'b0, touch_raw1 = 1'b0, scan_done, idle_state, scan_request;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, near_shift0 = 8'h00, near_shift1 = 8'h00;
    logic [7:0] near_adapt0 = 8'hff, near_adapt1 = 8'hff, reg_rdata;
    logic [2:0] fault_code = 3'h0, pin_fault_code;
    logic [4:0] sleep_code = 5'h00;
    logic [6:0] slave_bus_address;
    logic       sensor1_near_flag, sensor0_near_flag, sensor1_touch_flag, sensor0_touch_flag;
    logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h02, 5'h13};
    int         ms [4] = '{1, 2, 4, 1};
    int         n_errors = 0, checks = 0, gap;

    touch_regs #(.MS_CYCLES(MSC)) touch_regs_inst (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .txn_start, .slave_bus_address, .near_shift0, .near_shift1,
        .near_adapt0, .near_adapt1, .touch_raw0, .touch_raw1, .fault_code, .scan_done,
        .sleep_code, .sensor1_near_flag, .sensor0_near_flag, .sensor1_touch_flag,
        .sensor0_touch_flag, .pin_fault_code, .idle_state, .scan_request);
    scan_model scan_model_inst (.clk, .resetn, .scan_request, .scan_done);

    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // read data lands at the edge that samples the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // sel 1 waits for idle, sel 0 for a scan done pulse
    task automatic wait_hi(input int sel, input int lim);
        int i;
        for (i = 0; i < lim && (sel ? idle_state : scan_done) !== 1'b1; i++)
            cyc(1);
        if (i == lim)
        begin
            n_errors++;
            $display("unexpected at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
            complete_run();
        end
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h00, 8'h00);
        rd(8'h01, 8'hff);
        rd(8'h02, 8'h01);
        rd(8'h03, 8'he6);
        rd(8'h04, 8'h00);
        wr(8'h00, 8'h10);
        rd(8'h00, 8'h10);
        wr(8'h03, 8'ha1);
        rd(8'h03, 8'ha0);
        chk({1'b0, slave_bus_address}, 8'h73);
        @(posedge clk);
        txn_start <= 1'b1;
        @(posedge clk);
        txn_start <= 1'b0;
        #1 chk({1'b0, slave_bus_address}, 8'h50);
        rd(8'h07, 8'h00);
        // floor above the adaptive level on sensor 0, below it on sensor 1
        @(posedge clk);
        near_adapt0 <= 8'h08;
        near_adapt1 <= 8'h20;
        near_shift0 <= 8'h0f;
        near_shift1 <= 8'h1f;
        touch_raw1  <= 1'b1;
        fault_code  <= 3'h5;
        cyc(2);
        chk({4'h0, sensor1_near_flag, sensor0_near_flag, sensor1_touch_flag,
             sensor0_touch_flag}, 8'h02);
        rd(8'h04, 8'h52);
        @(posedge clk);
        near_shift0 <= 8'h10;
        near_shift1 <= 8'h20;
        cyc(2);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h5e);
        for (int f = 0; f < 8; f++)
        begin
            @(posedge clk);
            fault_code <= f[2:0];
            cyc(2);
            chk({5'h00, pin_fault_code}, f[7:0]);
        end
        // short reload: two scans without change end the detection
        wr(8'h01, 8'h02);
        wr(8'h02, 8'h00);
        @(posedge clk);
        near_shift0 <= 8'h00;
        near_shift1 <= 8'h00;
        touch_raw1  <= 1'b0;
        touch_raw0  <= 1'b1;
        cyc(2);
        chk({7'h00, sensor0_touch_flag}, 8'h01);
        wait_hi(1, 40);
        chk({7'h00, sensor0_touch_flag}, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            sleep_code <= codes[k];
            #1 wait_hi(0, 600);
            cyc(1);
            wait_hi(0, 600);
            gap = 0;
            while (scan_request !== 1'b1 && gap < 600)
            begin
                cyc(1);
                gap++;
            end
            chk({7'h00, gap >= MSC * ms[k] && gap <= MSC * ms[k] + 3}, 8'h01);
        end
        @(posedge clk);
        touch_raw0 <= 1'b0;
        cyc(2);
        chk({7'h00, idle_state}, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
